// ==== inc/pdt_pkg.sv ====
// Constants, field layouts, decode functions and bus carrier for the
// prescaler and dual timer. Assumes a 4-bit register port driven by the CPU.
package pdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PRESC_W = 11;
  localparam int CNT_W   = 8;
  localparam int DIG_W   = 4;
  localparam int ADDR_W  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses, as printed
  localparam logic [ADDR_W-1:0] ADR_TA_IRQ = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_TB_IRQ = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_TA_CTL = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_TB_CTL = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_TB_LO  = 4'ha;
  localparam logic [ADDR_W-1:0] ADR_TB_HI  = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TB_FLAG_BIT   = 0;
  localparam int TB_MASK_BIT   = 1;
  localparam int TA_FLAG_BIT   = 2;
  localparam int TA_MASK_BIT   = 3;
  localparam int TB_RELOAD_BIT = 3;
  localparam logic [2:0] TB_EXT_SEL = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PRESC_W-1:0] PRESC_RST  = 11'h000;
  localparam logic [CNT_W-1:0]   CNT_RST    = 8'h00;
  localparam logic [CNT_W-1:0]   CNT_MAX    = 8'hff;
  localparam logic [2:0]         TA_CTL_RST = 3'h0;
  localparam logic [DIG_W-1:0]   TB_CTL_RST = 4'h0;
  localparam logic [DIG_W-1:0]   DIG_ZERO   = 4'h0;
  localparam logic               FLAG_RST   = 1'b0;
  localparam logic               MASK_RST   = 1'b1;
  localparam logic               EXT_IDLE   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus request carrier
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DIG_W-1:0]  wdata;
  } pdt_bus_req_t;

  ////////////////////////////////////////////////////////////////////////////
  // Divide ratio as a power of two
  function automatic logic [3:0] pdt_ta_log2(input logic [2:0] code);
    logic [3:0] lg;
    case (code)
      3'h0:    lg = 4'hb;
      3'h1:    lg = 4'ha;
      3'h2:    lg = 4'h9;
      3'h3:    lg = 4'h7;
      3'h4:    lg = 4'h5;
      3'h5:    lg = 4'h3;
      3'h6:    lg = 4'h2;
      default: lg = 4'h1;
    endcase
    return lg;
  endfunction

  function automatic logic [3:0] pdt_tb_log2(input logic [2:0] code);
    logic [3:0] lg;
    case (code)
      3'h0:    lg = 4'hb;
      3'h1:    lg = 4'h9;
      3'h2:    lg = 4'h7;
      3'h3:    lg = 4'h5;
      3'h4:    lg = 4'h3;
      3'h5:    lg = 4'h2;
      default: lg = 4'h1;
    endcase
    return lg;
  endfunction

  // True once every 2**lg counts: the low lg bits are all ones
  function automatic logic pdt_tap_hit(input logic [PRESC_W-1:0] p,
                                       input logic [3:0] lg);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((12'h001 << lg) - 12'h001);
    return (p & m) == m;
  endfunction

endpackage

// ==== hw/pdt_top.sv ====
// Prescaler, free-running timer A and reload timer/event counter B.
// Assumes a single-cycle CPU register port and synchronous stop_mode.
//
// Chosen here: the plain strobed port.
module pdt_top
  import pdt_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               stop_mode,
  input  wire logic               external_event_input,
  input  wire pdt_bus_req_t       bus_req,
  output logic [DIG_W-1:0]        rdata_q,
  output logic [PRESC_W-1:0]      presc_q,
  output logic                    timer_a_irq_q,
  output logic                    timer_b_irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0]       ta_ctl_q;
  logic [DIG_W-1:0] tb_ctl_q;
  logic [DIG_W-1:0] tb_pend_q;
  logic             tb_pend_v_q;
  logic [CNT_W-1:0] ta_cnt_q;
  logic [CNT_W-1:0] tb_cnt_q;
  logic [CNT_W-1:0] tb_cnt_d;
  logic [CNT_W-1:0] reload_q;
  logic [DIG_W-1:0] low_latch_q;
  logic             ta_flag_q;
  logic             ta_mask_q;
  logic             tb_flag_q;
  logic             tb_mask_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire run       = !stop_mode;
  wire wr_ta_irq = bus_req.wr && (bus_req.addr == ADR_TA_IRQ);
  wire wr_tb_irq = bus_req.wr && (bus_req.addr == ADR_TB_IRQ);
  wire wr_ta_ctl = bus_req.wr && (bus_req.addr == ADR_TA_CTL);
  wire wr_tb_ctl = bus_req.wr && (bus_req.addr == ADR_TB_CTL);
  wire wr_tb_lo  = bus_req.wr && (bus_req.addr == ADR_TB_LO);
  wire wr_tb_hi  = bus_req.wr && (bus_req.addr == ADR_TB_HI);
  wire rd_ta_irq = bus_req.rd && (bus_req.addr == ADR_TA_IRQ);
  wire rd_tb_irq = bus_req.rd && (bus_req.addr == ADR_TB_IRQ);
  wire rd_tb_lo  = bus_req.rd && (bus_req.addr == ADR_TB_LO);
  wire rd_tb_hi  = bus_req.rd && (bus_req.addr == ADR_TB_HI);

  // Control addresses read as zero: they are write-only
  wire [DIG_W-1:0] ta_irq_view = {ta_mask_q, ta_flag_q, 2'b00};
  wire [DIG_W-1:0] tb_irq_view = {2'b00, tb_mask_q, tb_flag_q};
  wire [DIG_W-1:0] rdata_d =
    rd_ta_irq ? ta_irq_view :
    rd_tb_irq ? tb_irq_view :
    rd_tb_hi  ? tb_cnt_q[7:4] :
    rd_tb_lo  ? low_latch_q :
                DIG_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= PRESC_RST;
    end else if (run) begin
      presc_q <= presc_q + 11'h001;
    end
  end

  // Taps are enables, not derived clocks, so every counter stays on clk
  wire ta_tap = pdt_tap_hit(presc_q, pdt_ta_log2(ta_ctl_q));
  wire tb_tap = pdt_tap_hit(presc_q, pdt_tb_log2(tb_ctl_q[2:0]));
  wire tb_ext = (tb_ctl_q[2:0] == TB_EXT_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // Event input synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= EXT_IDLE;
      ext_s2_q <= EXT_IDLE;
      ext_s3_q <= EXT_IDLE;
    end else begin
      ext_s1_q <= external_event_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  wire ext_fall = ext_s3_q && !ext_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count enables
  wire ta_tick = run && ta_tap;
  wire tb_tick = run && (tb_ext ? ext_fall : tb_tap);
  wire ta_ovf  = ta_tick && (ta_cnt_q == CNT_MAX);
  // A load on the same cycle wins, so that cycle never overflows
  wire tb_ovf  = tb_tick && (tb_cnt_q == CNT_MAX) && !wr_tb_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ta_ctl_q <= TA_CTL_RST;
    end else if (wr_ta_ctl) begin
      ta_ctl_q <= bus_req.wdata[2:0];
    end
  end

  // One staging stage delays the new timer B mode by a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_pend_q   <= TB_CTL_RST;
      tb_pend_v_q <= 1'b0;
    end else begin
      tb_pend_v_q <= wr_tb_ctl;
      if (wr_tb_ctl) begin
        tb_pend_q <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_ctl_q <= TB_CTL_RST;
    end else if (tb_pend_v_q) begin
      tb_ctl_q <= tb_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer A
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ta_cnt_q <= CNT_RST;
    end else if (ta_tick) begin
      ta_cnt_q <= ta_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer B reload register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_q <= CNT_RST;
    end else if (wr_tb_lo) begin
      reload_q[3:0] <= bus_req.wdata;
    end else if (wr_tb_hi) begin
      reload_q[7:4] <= bus_req.wdata;
    end
  end

  // Timer B counter
  always_comb begin
    tb_cnt_d = tb_cnt_q;
    if (wr_tb_hi) begin
      tb_cnt_d = {bus_req.wdata, reload_q[3:0]};
    end else if (tb_tick) begin
      if (tb_cnt_q != CNT_MAX) begin
        tb_cnt_d = tb_cnt_q + 8'h01;
      end else if (tb_ctl_q[TB_RELOAD_BIT]) begin
        tb_cnt_d = reload_q;
      end else begin
        tb_cnt_d = CNT_RST;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_cnt_q <= CNT_RST;
    end else begin
      tb_cnt_q <= tb_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and low-digit latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_latch_q <= DIG_ZERO;
    end else if (rd_tb_hi) begin
      low_latch_q <= tb_cnt_q[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= DIG_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flags and masks; hardware set beats a software clear
  wire ta_flag_d = ta_ovf ? 1'b1 :
                   wr_ta_irq ? bus_req.wdata[TA_FLAG_BIT] : ta_flag_q;
  wire tb_flag_d = tb_ovf ? 1'b1 :
                   wr_tb_irq ? bus_req.wdata[TB_FLAG_BIT] : tb_flag_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ta_flag_q <= FLAG_RST;
      tb_flag_q <= FLAG_RST;
    end else begin
      ta_flag_q <= ta_flag_d;
      tb_flag_q <= tb_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ta_mask_q <= MASK_RST;
      tb_mask_q <= MASK_RST;
    end else begin
      if (wr_ta_irq) begin
        ta_mask_q <= bus_req.wdata[TA_MASK_BIT];
      end
      if (wr_tb_irq) begin
        tb_mask_q <= bus_req.wdata[TB_MASK_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_a_irq_q <= 1'b0;
      timer_b_irq_q <= 1'b0;
    end else begin
      timer_a_irq_q <= ta_flag_q && !ta_mask_q;
      timer_b_irq_q <= tb_flag_q && !tb_mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  presc_count_a: assert property (
    run |=> presc_q == PRESC_W'($past(presc_q) + 11'h001))
    else $error("prescaler did not advance");

  presc_hold_a: assert property (
    stop_mode |=> $stable(presc_q) && $stable(ta_cnt_q))
    else $error("counters moved in stop mode");

  ta_fast_a: assert property (
    (ta_ctl_q == 3'h7) && run && !wr_ta_ctl |-> ta_tick == presc_q[0])
    else $error("timer A divide by two wrong");

  ta_wrap_a: assert property (
    ta_ovf |=> (ta_cnt_q == CNT_RST) && ta_flag_q)
    else $error("timer A overflow wrong");

  sequence tb_mode_wr_s;
    wr_tb_ctl ##1 !wr_tb_ctl;
  endsequence

  tb_mode_delay_a: assert property (
    tb_mode_wr_s |-> $stable(tb_ctl_q) ##1 tb_ctl_q == $past(bus_req.wdata, 2))
    else $error("timer B mode delay wrong");

  tb_load_a: assert property (
    wr_tb_hi |=> tb_cnt_q == {$past(bus_req.wdata), reload_q[3:0]})
    else $error("timer B load wrong");

  tb_reload_a: assert property (
    tb_ovf && tb_ctl_q[TB_RELOAD_BIT] && !wr_tb_lo
      |=> tb_cnt_q == reload_q && tb_flag_q)
    else $error("timer B reload wrong");

  tb_ext_a: assert property (
    tb_ext && run && !wr_tb_hi && $fell(ext_s2_q)
      |=> tb_cnt_q != $past(tb_cnt_q))
    else $error("event edge not counted");

  sequence hi_then_lo_s;
    rd_tb_hi ##1 rd_tb_lo;
  endsequence

  low_latch_a: assert property (
    hi_then_lo_s |=> rdata_q == $past(tb_cnt_q[3:0], 2))
    else $error("low digit not latched");

  flag_win_a: assert property (
    tb_ovf && wr_tb_irq |=> tb_flag_q)
    else $error("flag clear beat set");

  irq_gate_a: assert property (
    ta_flag_q && ta_mask_q |=> !timer_a_irq_q)
    else $error("masked request passed");

endmodule

// ==== dv/pdt_event_src.sv ====
// Event pin model for the timer B external count input.
// Assumes the bench raises fire for one clock for every falling edge wanted.
module pdt_event_src (
  input  wire logic clk,
  input  wire logic fire,
  output logic      ev
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] low_q = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin idles high; each event holds it low for four clocks, long enough for
  // a two-stage synchroniser to see it
  always @(posedge clk) begin
    if (fire) begin
      low_q <= 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end

  assign ev = (low_q == 3'h0);
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the prescaler and dual timer.
// Assumes the register port contract of pdt_top and a 25 MHz clock.
module testbench;
  import pdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk       = 1'b0;
  logic               rst       = 1'b1;
  logic               stop_mode = 1'b0;
  logic               fire      = 1'b0;
  logic               ev;
  pdt_bus_req_t       bus_req   = '0;
  logic [DIG_W-1:0]   rdata_q;
  logic [DIG_W-1:0]   d;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] p0;
  logic               ta_irq;
  logic               tb_irq;
  int                 n_errors    = 0;
  int                 checks_done = 0;
  int                 n;

  always #20 clk = ~clk;

  pdt_top u_pdt_top (
    .clk                  (clk),
    .rst                  (rst),
    .stop_mode            (stop_mode),
    .external_event_input (ev),
    .bus_req              (bus_req),
    .rdata_q              (rdata_q),
    .presc_q              (presc_q),
    .timer_a_irq_q        (ta_irq),
    .timer_b_irq_q        (tb_irq)
  );

  pdt_event_src u_pdt_event_src (
    .clk  (clk),
    .fire (fire),
    .ev   (ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk_dig(input logic [3:0] got, input logic [3:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_presc(input logic [10:0] got, input logic [10:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_in(input int got, input int lo, input int hi, input string m);
    checks_done++;
    if (got < lo || got > hi) fail(m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [3:0] dt);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, a, dt};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp, input string m);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, a, 4'h0};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rdata_q;
    chk_dig(d, exp, m);
  endtask

  // Bounded wait on a request output; counts cycles spent
  task automatic wait_irq(input bit tb, input int lim);
    n = 0;
    while ((tb ? tb_irq : ta_irq) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > lim) begin
        fail("request never raised");
        test_done();
      end
    end
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk_presc(presc_q, 11'h001, "prescaler start");
    rd_chk(ADR_TA_IRQ, 4'h8, "timer a bits reset");
    rd_chk(ADR_TB_IRQ, 4'h2, "timer b bits reset");
    rd_chk(ADR_TA_CTL, 4'h0, "write-only control read");
    rd_chk(4'h5, 4'h0, "unmapped read");
    rd_chk(ADR_TB_HI, 4'h0, "count high reset");
    rd_chk(ADR_TB_LO, 4'h0, "count low reset");
    $display("test reset done");

    // Divide by 2: 256 ticks of two clocks each before the wrap
    wr(ADR_TA_IRQ, 4'h0);
    wr(ADR_TA_CTL, 4'h7);
    wait_irq(1'b0, 700);
    chk_in(n, 505, 518, "timer a interval");
    rd_chk(ADR_TA_IRQ, 4'h4, "timer a flag set");
    wr(ADR_TA_IRQ, 4'h8);
    repeat (2) @(posedge clk);
    #1 chk_bit(ta_irq, 1'b0, "timer a masked");
    $display("test timer a done");

    // Loads and latched reads while stop mode freezes the counters
    @(posedge clk);
    stop_mode <= 1'b1;
    wr(ADR_TB_LO, 4'h5);
    wr(ADR_TB_HI, 4'hc);
    rd_chk(ADR_TB_HI, 4'hc, "count high after load");
    wr(ADR_TB_LO, 4'h9);
    wr(ADR_TB_HI, 4'h3);
    rd_chk(ADR_TB_LO, 4'h5, "latched low digit");
    rd_chk(ADR_TB_HI, 4'h3, "second load high");
    rd_chk(ADR_TB_LO, 4'h9, "second load low");
    p0 = presc_q;
    repeat (5) @(posedge clk);
    #1 chk_presc(presc_q, p0, "prescaler frozen");
    @(posedge clk);
    stop_mode <= 1'b0;
    $display("test load and latch done");

    // External events with auto-reload, then without
    wr(ADR_TB_IRQ, 4'h0);
    wr(ADR_TB_CTL, 4'hf);
    repeat (2) @(posedge clk);
    wr(ADR_TB_LO, 4'he);
    wr(ADR_TB_HI, 4'hf);
    pulses(1);
    rd_chk(ADR_TB_HI, 4'hf, "event count high");
    rd_chk(ADR_TB_LO, 4'hf, "event count low");
    chk_bit(tb_irq, 1'b0, "no early overflow");
    pulses(1);
    rd_chk(ADR_TB_HI, 4'hf, "reload high");
    rd_chk(ADR_TB_LO, 4'he, "reload low");
    chk_bit(tb_irq, 1'b1, "timer b request");
    rd_chk(ADR_TB_IRQ, 4'h1, "timer b flag");
    wr(ADR_TB_IRQ, 4'h0);
    wr(ADR_TB_CTL, 4'h7);
    repeat (2) @(posedge clk);
    wr(ADR_TB_LO, 4'hf);
    wr(ADR_TB_HI, 4'hf);
    pulses(1);
    rd_chk(ADR_TB_HI, 4'h0, "wrap high");
    rd_chk(ADR_TB_LO, 4'h0, "wrap low");
    rd_chk(ADR_TB_IRQ, 4'h1, "flag on wrap");
    $display("test event mode done");

    // Prescaler clock divide by 2, then the same with the mask set
    wr(ADR_TB_IRQ, 4'h0);
    wr(ADR_TB_CTL, 4'h6);
    repeat (2) @(posedge clk);
    wr(ADR_TB_LO, 4'h0);
    wr(ADR_TB_HI, 4'hf);
    wait_irq(1'b1, 60);
    chk_in(n, 28, 36, "timer b interval");
    wr(ADR_TB_IRQ, 4'h2);
    wr(ADR_TB_LO, 4'h0);
    wr(ADR_TB_HI, 4'hf);
    repeat (40) @(posedge clk);
    #1 chk_bit(tb_irq, 1'b0, "masked request");
    rd_chk(ADR_TB_IRQ, 4'h3, "flag under mask");
    // Divide by 4: sixteen ticks of four clocks each from the load
    wr(ADR_TB_IRQ, 4'h0);
    wr(ADR_TB_CTL, 4'h5);
    repeat (2) @(posedge clk);
    wr(ADR_TB_LO, 4'h0);
    wr(ADR_TB_HI, 4'hf);
    wait_irq(1'b1, 100);
    chk_in(n, 58, 68, "timer b divide by four");
    $display("test timer b clock done");
    test_done();
  end
endmodule
